/* src/npulse_pkg.sv */
// Purpose: shared constants for the complementary n-pulse generator
// Assumes: 32-bit register port, byte offsets of word-aligned registers
// Notes:   widths fixed at 16-bit counters
package npulse_pkg;
  timeunit 1ns;
  timeprecision 1ps;
  // register byte offsets
  localparam logic [7:0] GEN_CTRL_OFS   = 8'h00;
  localparam logic [7:0] GEN_MODE_OFS   = 8'h04;
  localparam logic [7:0] GEN_PSC_OFS    = 8'h08;
  localparam logic [7:0] GEN_ARR_OFS    = 8'h0C;
  localparam logic [7:0] GEN_CMP_OFS    = 8'h10;
  localparam logic [7:0] GEN_EVT_OFS    = 8'h14;
  localparam logic [7:0] WIN_CTRL_OFS   = 8'h18;
  localparam logic [7:0] WIN_PSC_OFS    = 8'h1C;
  localparam logic [7:0] WIN_ARR_OFS    = 8'h20;
  localparam logic [7:0] IRQ_STAT_OFS   = 8'h24;
  localparam logic [7:0] IRQ_MASK_OFS   = 8'h28;
  localparam logic [7:0] COUNT_OFS      = 8'h2C;
  // gen control bits
  localparam int CTL_EN       = 0;
  localparam int CTL_PRELOAD  = 1;
  localparam int CTL_COMMUTATION_UPDATE_SOURCE     = 2;
  localparam int CTL_MRESET   = 3;
  localparam int CTL_COMMUTATION_IRQ_ENABLE    = 4;
  // window control bits
  localparam int WCTL_EN      = 0;
  localparam int WCTL_MUPD    = 1;
  localparam int WCTL_SRESET  = 2;
  // event bits
  localparam int EVT_UG       = 0;
  // status bits
  localparam int ST_COM       = 0;
  localparam int ST_GUPD      = 1;
  localparam int ST_WUPD      = 2;
  // compare modes
  localparam logic [2:0] MODE_FORCED_INACTIVE = 3'h4;
  localparam logic [2:0] MODE_PWM1            = 3'h6;
  // reset values
  localparam logic [15:0] ARR_RESET = 16'hFFFF;
  localparam logic [2:0]  MODE_RESET = 3'h0;
endpackage : npulse_pkg

/* src/npulse_gen.sv */
// Purpose: generator timer plus window timer for n complementary pulses
// Assumes: register strobes synchronous to sys_clk_i, one per cycle
// Notes:   read data valid the cycle after the read strobe
//
// Local design decisions: the placing of the registers and the strobed register port.
module npulse_gen (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // outputs
  output logic             chan_o,
  output logic             chan_n_o,
  output logic             irq_o,
  output logic             trigger_out_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        rst_meta_q, rst_n_q;
  logic [4:0]  gctl_q;
  logic [2:0]  wctl_q;
  logic [2:0]  mode_pre_q, mode_act_q;
  logic [15:0] gpsc_q, garr_q, gcmp_pre_q, gcmp_act_q, garr_act_q;
  logic [15:0] wpsc_q, warr_q;
  logic [15:0] gpc_q, gcnt_q, wpc_q, wcnt_q;
  logic [2:0]  stat_q, mask_q;
  logic        gen_en_d1_q, trig_d1_q, win_trig_q;
  logic        ug, gtick, wtick, gupd, wupd, gen_start, com_evt;
  logic        win_reset, pwm_lvl;

  // reset release through two flops
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  function automatic logic hit(input logic [7:0] ofs);
    hit = wr_i && (addr_i == ofs);
  endfunction : hit

  // configuration registers
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gctl_q     <= 5'h00;
      wctl_q     <= 3'h0;
      mode_pre_q <= npulse_pkg::MODE_RESET;
      gpsc_q     <= 16'h0000;
      garr_q     <= npulse_pkg::ARR_RESET;
      gcmp_pre_q <= 16'h0000;
      wpsc_q     <= 16'h0000;
      warr_q     <= npulse_pkg::ARR_RESET;
      mask_q     <= 3'h0;
    end else begin
      if (hit(npulse_pkg::GEN_CTRL_OFS)) gctl_q <= wdata_i[4:0];
      if (hit(npulse_pkg::WIN_CTRL_OFS)) wctl_q <= wdata_i[2:0];
      if (hit(npulse_pkg::GEN_MODE_OFS)) mode_pre_q <= wdata_i[2:0];
      if (hit(npulse_pkg::GEN_PSC_OFS))  gpsc_q <= wdata_i[15:0];
      if (hit(npulse_pkg::GEN_ARR_OFS))  garr_q <= wdata_i[15:0];
      if (hit(npulse_pkg::GEN_CMP_OFS))  gcmp_pre_q <= wdata_i[15:0];
      if (hit(npulse_pkg::WIN_PSC_OFS))  wpsc_q <= wdata_i[15:0];
      if (hit(npulse_pkg::WIN_ARR_OFS))  warr_q <= wdata_i[15:0];
      if (hit(npulse_pkg::IRQ_MASK_OFS)) mask_q <= wdata_i[2:0];
    end
  end

  // event decoding
  assign ug        = hit(npulse_pkg::GEN_EVT_OFS)
                     && wdata_i[npulse_pkg::EVT_UG];
  assign gen_start = gctl_q[npulse_pkg::CTL_EN] && !gen_en_d1_q;
  // master reset: trigger pulse on enable edge or update generate
  assign trigger_out_o = gctl_q[npulse_pkg::CTL_MRESET]
                         && (gen_start || ug);
  assign win_reset = wctl_q[npulse_pkg::WCTL_SRESET] && trigger_out_o;
  // commutation on rising edge of window trigger
  assign com_evt = gctl_q[npulse_pkg::CTL_COMMUTATION_UPDATE_SOURCE]
                   && win_trig_q && !trig_d1_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gen_en_d1_q <= 1'b0;
      trig_d1_q   <= 1'b0;
    end else begin
      gen_en_d1_q <= gctl_q[npulse_pkg::CTL_EN];
      trig_d1_q   <= win_trig_q;
    end
  end

  // generator prescaler and counter
  assign gtick = gctl_q[npulse_pkg::CTL_EN] && (gpc_q == gpsc_q);
  assign gupd  = (gtick && (gcnt_q == garr_act_q)) || ug;
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gpc_q  <= 16'h0000;
      gcnt_q <= 16'h0000;
    end else if (ug || gen_start) begin
      gpc_q  <= 16'h0000;
      gcnt_q <= 16'h0000;
    end else if (gctl_q[npulse_pkg::CTL_EN]) begin
      gpc_q <= gtick ? 16'h0000 : gpc_q + 16'h0001;
      if (gtick) gcnt_q <= gupd ? 16'h0000 : gcnt_q + 16'h0001;
    end
  end

  // shadow copies: period and compare load on update
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      garr_act_q <= npulse_pkg::ARR_RESET;
      gcmp_act_q <= 16'h0000;
    end else if (!gctl_q[npulse_pkg::CTL_PRELOAD] || gupd) begin
      garr_act_q <= garr_q;
      gcmp_act_q <= gcmp_pre_q;
    end
  end

  // mode shadow; with preload only commutation or ug transfers it
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_act_q <= npulse_pkg::MODE_RESET;
    end else if (!gctl_q[npulse_pkg::CTL_PRELOAD] || com_evt || ug) begin
      mode_act_q <= mode_pre_q;
    end
  end

  // window prescaler and counter
  assign wtick = wctl_q[npulse_pkg::WCTL_EN] && (wpc_q == wpsc_q);
  assign wupd  = wtick && (wcnt_q == warr_q);
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wpc_q  <= 16'h0000;
      wcnt_q <= 16'h0000;
    end else if (win_reset) begin
      wpc_q  <= 16'h0000;
      wcnt_q <= 16'h0000;
    end else if (wctl_q[npulse_pkg::WCTL_EN]) begin
      wpc_q <= wtick ? 16'h0000 : wpc_q + 16'h0001;
      if (wtick) wcnt_q <= wupd ? 16'h0000 : wcnt_q + 16'h0001;
    end
  end

  // window trigger: one-cycle pulse per update
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) win_trig_q <= 1'b0;
    else win_trig_q <= wctl_q[npulse_pkg::WCTL_MUPD] && wupd;
  end

  // channel output: forced mode drives both low together
  assign pwm_lvl = gcnt_q < gcmp_act_q;
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      chan_o   <= 1'b0;
      chan_n_o <= 1'b0;
    end else if (mode_act_q == npulse_pkg::MODE_PWM1) begin
      chan_o   <= pwm_lvl;
      chan_n_o <= !pwm_lvl;
    end else begin
      chan_o   <= 1'b0;
      chan_n_o <= 1'b0;
    end
  end

  // sticky status, set wins over write-one clear
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      stat_q <= 3'h0;
    end else begin
      stat_q <= (stat_q & ~(hit(npulse_pkg::IRQ_STAT_OFS) ? wdata_i[2:0]
                                                          : 3'h0))
              | {wupd, gupd,
                 com_evt && gctl_q[npulse_pkg::CTL_COMMUTATION_IRQ_ENABLE]};
    end
  end
  assign irq_o = |(stat_q & mask_q);

  // read port, one cycle latency; unmapped reads zero
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      case (addr_i)
        npulse_pkg::GEN_CTRL_OFS: rdata_o <= {27'h0, gctl_q};
        npulse_pkg::GEN_MODE_OFS: rdata_o <= {26'h0, mode_act_q, 1'b0,
                                              mode_pre_q[2:1]};
        npulse_pkg::GEN_PSC_OFS:  rdata_o <= {16'h0, gpsc_q};
        npulse_pkg::GEN_ARR_OFS:  rdata_o <= {16'h0, garr_q};
        npulse_pkg::GEN_CMP_OFS:  rdata_o <= {16'h0, gcmp_pre_q};
        npulse_pkg::WIN_CTRL_OFS: rdata_o <= {29'h0, wctl_q};
        npulse_pkg::WIN_PSC_OFS:  rdata_o <= {16'h0, wpsc_q};
        npulse_pkg::WIN_ARR_OFS:  rdata_o <= {16'h0, warr_q};
        npulse_pkg::IRQ_STAT_OFS: rdata_o <= {29'h0, stat_q};
        npulse_pkg::IRQ_MASK_OFS: rdata_o <= {29'h0, mask_q};
        npulse_pkg::COUNT_OFS:    rdata_o <= {wcnt_q, gcnt_q};
        default:                  rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // assertions: output levels per mode
  a_force_low: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    (mode_act_q == npulse_pkg::MODE_FORCED_INACTIVE) |=>
      (!chan_o && !chan_n_o))
    else $error("forced mode did not drive outputs low");
  a_same_state: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    (mode_act_q != npulse_pkg::MODE_PWM1) |=> (chan_o == chan_n_o))
    else $error("outputs differ in inactive mode");
  a_pwm_level: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    (mode_act_q == npulse_pkg::MODE_PWM1) |=>
      (chan_o == $past(pwm_lvl) && chan_n_o == !chan_o))
    else $error("pwm level wrong");
  a_chan_comp: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    chan_o |-> !chan_n_o)
    else $error("channel and complement both high");

  // commutation path
  a_com_copy: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    com_evt |=> (mode_act_q == $past(mode_pre_q)))
    else $error("commutation did not copy mode");
  a_com_edge: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    (gctl_q[npulse_pkg::CTL_COMMUTATION_UPDATE_SOURCE] && $rose(win_trig_q)) |-> com_evt)
    else $error("trigger edge missed");
  a_com_irq: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    (com_evt && gctl_q[npulse_pkg::CTL_COMMUTATION_IRQ_ENABLE]) |=> stat_q[0])
    else $error("commutation flag not set");
  a_cflag_hold: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    (stat_q[npulse_pkg::ST_COM] && !hit(npulse_pkg::IRQ_STAT_OFS))
    |=> stat_q[npulse_pkg::ST_COM])
    else $error("commutation flag lost");
  a_cflag_off: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    (!stat_q[npulse_pkg::ST_COM] && !gctl_q[npulse_pkg::CTL_COMMUTATION_IRQ_ENABLE])
    |=> !stat_q[npulse_pkg::ST_COM])
    else $error("commutation flag set while disabled");

  // burst end: window wrap, then commutation with forced mode waiting
  sequence s_win_wrap;
    wupd && wctl_q[npulse_pkg::WCTL_MUPD];
  endsequence : s_win_wrap
  sequence s_forced_com;
    com_evt && (mode_pre_q == npulse_pkg::MODE_FORCED_INACTIVE);
  endsequence : s_forced_com
  sequence s_both_low;
    !chan_o && !chan_n_o;
  endsequence : s_both_low
  a_burst_end: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    (s_win_wrap ##1 s_forced_com) |=> ##1 s_both_low)
    else $error("burst did not end with both outputs low");
  a_trig_to_com: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    (s_win_wrap ##1 (gctl_q[npulse_pkg::CTL_COMMUTATION_UPDATE_SOURCE] && !trig_d1_q))
    |-> com_evt)
    else $error("window wrap did not commutate");

  // window timer and master trigger
  a_win_trig: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    (wupd && wctl_q[npulse_pkg::WCTL_MUPD]) |=> win_trig_q)
    else $error("window trigger missing");
  a_win_reset: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    win_reset |=> (wcnt_q == 16'h0000))
    else $error("window counter not cleared");
  a_win_wrap: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    wupd |=> (wcnt_q == 16'h0000))
    else $error("window counter did not wrap");
  a_win_hold: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    (wctl_q[npulse_pkg::WCTL_EN] && !wtick && !win_reset) |=> $stable(wcnt_q))
    else $error("window counter moved without tick");
  a_wupd_flag: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    wupd |=> stat_q[npulse_pkg::ST_WUPD])
    else $error("window update flag not set");
  a_start_trig: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    (gen_start && gctl_q[npulse_pkg::CTL_MRESET]) |-> trigger_out_o)
    else $error("enable did not pulse trigger");
  a_start_clear: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    gen_start |=> (gcnt_q == 16'h0000))
    else $error("enable did not clear counter");

  // generator counter, update generate and preload
  a_ug_load: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    ug |=> (gcnt_q == 16'h0000 && garr_act_q == $past(garr_q)))
    else $error("update generate did not load");
  a_ug_mode: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    ug |=> (mode_act_q == $past(mode_pre_q)))
    else $error("update generate did not move mode");
  a_prescale: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    (gctl_q[0] && !gtick && !ug && !gen_start) |=> $stable(gcnt_q))
    else $error("counter moved without tick");
  a_gen_wrap: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    (gtick && (gcnt_q == garr_act_q)) |=> (gcnt_q == 16'h0000))
    else $error("generator counter did not wrap");
  a_gen_count: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    (gtick && (gcnt_q != garr_act_q) && !ug && !gen_start)
    |=> (gcnt_q == $past(gcnt_q) + 16'h0001))
    else $error("generator counter did not step");
  a_gupd_flag: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    gupd |=> stat_q[npulse_pkg::ST_GUPD])
    else $error("generator update flag not set");
  a_shadow_hold: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    (gctl_q[npulse_pkg::CTL_PRELOAD] && !gupd) |=> $stable(gcmp_act_q))
    else $error("compare shadow moved between updates");
  a_mode_hold: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_q)
    (gctl_q[npulse_pkg::CTL_PRELOAD] && !com_evt && !ug)
    |=> $stable(mode_act_q))
    else $error("mode shadow moved without transfer");
endmodule : npulse_gen

/* bench/npulse_load_model.sv */
// Purpose: load on the channel pins, tallies pulses and triggers
// Assumes: pins sampled on sys_clk_i
// Notes:   a clipped tail pulse shorter than width_i is not tallied
module npulse_load_model (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  // observed pins
  input  wire logic        chan_i,
  input  wire logic        chan_n_i,
  input  wire logic        trig_i,
  input  wire logic [15:0] width_i,
  input  wire logic        clr_i,
  // tallies
  output logic      [7:0]  full_o,
  output logic      [7:0]  trig_o,
  output logic      [15:0] last_o,
  output logic             both_hi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] run_q;
  // high runs are measured so on-time and count come from the pins alone
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i || clr_i) begin
      run_q     <= 16'h0;
      full_o    <= 8'h0;
      trig_o    <= 8'h0;
      last_o    <= 16'h0;
      both_hi_o <= 1'b0;
    end else begin
      run_q <= chan_i ? run_q + 16'h1 : 16'h0;
      if (!chan_i && run_q != 16'h0) begin
        last_o <= run_q;
        if (run_q >= width_i) full_o <= full_o + 8'h1;
      end
      if (trig_i) trig_o <= trig_o + 8'h1;
      if (chan_i && chan_n_i) both_hi_o <= 1'b1;
    end
  end
endmodule : npulse_load_model

/* bench/npulse_gen_tb_top.sv */
// Purpose: self-checking bench for the n-pulse generator
// Assumes: one clock, register strobes driven here
// Notes:   ctrl bits: en, preload, commutation_update_source, master reset, irq enable
module npulse_gen_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        clr = 1'b0;
  logic [15:0] width = 16'h4;
  logic [31:0] rdata;
  logic        chan;
  logic        chan_n;
  logic        irq;
  logic        trig;
  logic        both_hi;
  logic [7:0]  full;
  logic [7:0]  trigs;
  logic [15:0] last;
  int          fails = 0;
  int          num_checks = 0;
  npulse_gen dut (.sys_clk_i(clk), .resetn_i(rstn), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .chan_o(chan),
    .chan_n_o(chan_n), .irq_o(irq), .trigger_out_o(trig));
  npulse_load_model load (.sys_clk_i(clk), .resetn_i(rstn), .chan_i(chan),
    .chan_n_i(chan_n), .trig_i(trig), .width_i(width), .clr_i(clr),
    .full_o(full), .trig_o(trigs), .last_o(last), .both_hi_o(both_hi));
  // free-running 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg
  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    check(rdata & m, exp);
  endtask : rd_chk
  task automatic clr_cnt;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask : clr_cnt
  task automatic t_reset;
    check({chan, chan_n, irq}, 32'h0);
    rd_chk(npulse_pkg::GEN_ARR_OFS, 32'hFFFF, 32'hFFFF);
    rd_chk(npulse_pkg::GEN_MODE_OFS, 32'h3F, 32'h0);
    wr_reg(8'h30, 32'h5);
    rd_chk(8'h30, 32'hFFFFFFFF, 32'h0);
  endtask : t_reset
  // preloaded mode stays hidden until the update bit moves it
  task automatic t_preload;
    wr_reg(npulse_pkg::GEN_CTRL_OFS, 32'h2);
    wr_reg(npulse_pkg::GEN_MODE_OFS, 32'h6);
    rd_chk(npulse_pkg::GEN_MODE_OFS, 32'h38, 32'h0);
    wr_reg(npulse_pkg::GEN_EVT_OFS, 32'h1);
    rd_chk(npulse_pkg::GEN_MODE_OFS, 32'h38, 32'h30);
  endtask : t_preload
  task automatic t_pwm(input logic [15:0] psc);
    wr_reg(npulse_pkg::GEN_PSC_OFS, {16'h0, psc});
    wr_reg(npulse_pkg::GEN_ARR_OFS, 32'h9);
    wr_reg(npulse_pkg::GEN_CMP_OFS, 32'h4);
    wr_reg(npulse_pkg::GEN_EVT_OFS, 32'h1);
    width <= 16'h4 * (psc + 16'h1);
    clr_cnt;
    wr_reg(npulse_pkg::GEN_CTRL_OFS, 32'h3);
    repeat (58 * (psc + 1)) @(posedge clk);
    #1;
    check(full, 32'h6);
    check(last, {16'h0, width});
    check(both_hi, 32'h0);
    wr_reg(npulse_pkg::GEN_CTRL_OFS, 32'h2);
  endtask : t_pwm
  // burst of three pulses, then forced low by the window's trigger
  task automatic t_burst;
    wr_reg(npulse_pkg::WIN_ARR_OFS, 32'h1D);
    wr_reg(npulse_pkg::WIN_CTRL_OFS, 32'h7);
    wr_reg(npulse_pkg::GEN_PSC_OFS, 32'h0);
    wr_reg(npulse_pkg::GEN_MODE_OFS, 32'h6);
    wr_reg(npulse_pkg::GEN_EVT_OFS, 32'h1);
    wr_reg(npulse_pkg::GEN_MODE_OFS, 32'h4);
    width <= 16'h4;
    clr_cnt;
    wr_reg(npulse_pkg::GEN_CTRL_OFS, 32'h1F);
    repeat (75) @(posedge clk);
    #1;
    check(trigs, 32'h1);
    check(full, 32'h3);
    check({chan, chan_n}, 32'h0);
    check(irq, 32'h0);
    rd_chk(npulse_pkg::GEN_MODE_OFS, 32'h38, 32'h20);
    rd_chk(npulse_pkg::IRQ_STAT_OFS, 32'h1, 32'h1);
    wr_reg(npulse_pkg::IRQ_MASK_OFS, 32'h1);
    #1;
    check(irq, 32'h1);
    wr_reg(npulse_pkg::WIN_CTRL_OFS, 32'h0);
    wr_reg(npulse_pkg::IRQ_STAT_OFS, 32'h1);
    #1;
    check(irq, 32'h0);
  endtask : t_burst
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_preload;
    t_pwm(16'h0);
    t_pwm(16'h1);
    t_burst;
    print_verdict;
  end
  // the whole run needs a few hundred cycles
  initial begin
    #40000;
    fails++;
    print_verdict;
  end
endmodule : npulse_gen_tb_top
